// [hw/tppio_pkg.sv]
// constants shared by the three-port parallel interface unit
// assumes a synchronous host bus on core_clk with one-cycle strobes
package tppio_pkg;

	// host addresses of the four registers
	localparam logic [15:0] ADDR_PORT_A = 16'h00c8;
	localparam logic [15:0] ADDR_PORT_B = 16'h00ca;
	localparam logic [15:0] ADDR_PORT_C = 16'h00cc;
	localparam logic [15:0] ADDR_CTRL = 16'h00ce;

	// mode-definition word fields
	localparam int CW_MODE_SET = 7;
	localparam int CW_A_MODE_HI = 6;
	localparam int CW_A_MODE_LO = 5;
	localparam int CW_A_DIR = 4;
	localparam int CW_CU_DIR = 3;
	localparam int CW_B_MODE = 2;
	localparam int CW_B_DIR = 1;
	localparam int CW_CL_DIR = 0;
	localparam logic [1:0] A_MODE_STROBED = 2'h1;

	// single-bit word fields
	localparam int BSR_SEL_HI = 3;
	localparam int BSR_SEL_LO = 1;
	localparam int BSR_VAL = 0;

	// port c lines taken over by handshakes
	localparam int PC_A_INTR = 3;
	localparam int PC_A_STB = 4;
	localparam int PC_A_IBF = 5;
	localparam int PC_A_ACK = 6;
	localparam int PC_A_OBF = 7;
	localparam int PC_B_INTR = 0;
	localparam int PC_B_FLAG = 1;
	localparam int PC_B_STB = 2;

	// values after reset
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [6:0] CW_RST = 7'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;

endpackage : tppio_pkg

// [hw/tppio_hs_if.sv]
// handshake channel bundle between the port unit and one strobed channel
// assumes both ends run on core_clk; strobe inputs already synchronised
`timescale 1ns/1ps
interface tppio_hs_if;
	logic clr; // mode rewrite, clears flags
	logic rd; // host read of the port, one cycle
	logic wr; // host write of the port, one cycle
	logic m_in; // strobed input role active
	logic m_out; // latched output role active
	logic inte_in; // input interrupt enable
	logic inte_out; // output interrupt enable
	logic stb_n; // peripheral strobe, low active
	logic ack_n; // peripheral acknowledge, low active
	logic [7:0] pins; // synchronised port lines
	logic ibf; // input buffer full
	logic obf_n; // output buffer full, low active
	logic intr; // channel interrupt request
	logic [7:0] in_latch; // strobed-in data

	modport ctl (output clr, rd, wr, m_in, m_out, inte_in, inte_out, stb_n, ack_n, pins,
		input ibf, obf_n, intr, in_latch);
	modport chan (input clr, rd, wr, m_in, m_out, inte_in, inte_out, stb_n, ack_n, pins,
		output ibf, obf_n, intr, in_latch);
endinterface : tppio_hs_if

// [hw/tppio_sync.sv]
// two-flop synchroniser for the port pins
// assumes inputs asynchronous to core_clk
`timescale 1ns/1ps
module tppio_sync #(
	parameter int W = 24
) (
	input wire logic core_clk, // unit clock
	input wire logic rst_n, // async reset, low active
	input wire logic [W-1:0] din, // raw pin levels
	output logic [W-1:0] dout // synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tppio_sync_t;

	tppio_sync_t q;
	tppio_sync_t d;

	// first stage feeds only the second
	always_comb begin
		d.s1 = din;
		d.s2 = q.s1;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dout = q.s2;
endmodule : tppio_sync

// [hw/tppio_hs.sv]
// one strobed channel: input latch with buffer-full, output buffer-full
// assumes stb_n and ack_n synchronised, rd and wr one-cycle host strobes
`timescale 1ns/1ps
module tppio_hs (
	input wire logic core_clk, // unit clock
	input wire logic rst_n, // async reset, low active
	tppio_hs_if.chan hs // channel bundle
);
	typedef struct packed {
		logic [7:0] latch;
		logic ibf;
		logic obf;
		logic intr_i;
		logic intr_o;
		logic stb_q;
		logic ack_q;
	} tppio_hs_state_t;

	tppio_hs_state_t q;
	tppio_hs_state_t d;
	logic stb_fall;
	logic stb_rise;
	logic ack_fall;
	logic ack_rise;

	// edges of the peripheral handshake lines
	assign stb_fall = q.stb_q & ~hs.stb_n;
	assign stb_rise = ~q.stb_q & hs.stb_n;
	assign ack_fall = q.ack_q & ~hs.ack_n;
	assign ack_rise = ~q.ack_q & hs.ack_n;

	// clears first, sets after, so a same-cycle event is kept
	always_comb begin
		d = q;
		d.stb_q = hs.stb_n;
		d.ack_q = hs.ack_n;
		if (hs.clr) begin
			d.latch = tppio_pkg::LATCH_RST;
			d.ibf = 1'b0;
			d.obf = 1'b0;
			d.intr_i = 1'b0;
			d.intr_o = 1'b0;
		end else begin
			if (hs.m_in) begin
				if (hs.rd) begin
					d.ibf = 1'b0;
					d.intr_i = 1'b0;
				end
				if (stb_fall) begin
					d.latch = hs.pins;
					d.ibf = 1'b1;
				end
				if (stb_rise && q.ibf) begin
					d.intr_i = 1'b1;
				end
			end else begin
				d.ibf = 1'b0;
				d.intr_i = 1'b0;
			end
			if (hs.m_out) begin
				if (ack_fall) begin
					d.obf = 1'b0;
				end
				if (hs.wr) begin
					d.obf = 1'b1;
					d.intr_o = 1'b0;
				end
				if (ack_rise && !q.obf) begin
					d.intr_o = 1'b1;
				end
			end else begin
				d.obf = 1'b0;
				d.intr_o = 1'b0;
			end
		end
	end

	// strobe lines idle high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{latch: 8'h00, ibf: 1'b0, obf: 1'b0, intr_i: 1'b0, intr_o: 1'b0,
				stb_q: 1'b1, ack_q: 1'b1};
		end else begin
			q <= d;
		end
	end

	// enables gate the request, not the sticky flag
	assign hs.intr = (q.intr_i & hs.inte_in) | (q.intr_o & hs.inte_out);
	assign hs.ibf = q.ibf;
	assign hs.obf_n = ~q.obf;
	assign hs.in_latch = q.latch;
endmodule : tppio_hs

// [hw/tppio_top.sv]
// three-port parallel interface unit: ports a, b, c and control word
// assumes a synchronous host bus on core_clk; pins asynchronous to it
`timescale 1ns/1ps

module tppio_top (
	input wire logic core_clk, // unit clock, 250 MHz
	input wire logic rst_n, // async reset, low active
	input wire logic [15:0] host_addr, // host i/o address
	input wire logic host_rd, // one-cycle read strobe
	input wire logic host_wr, // one-cycle write strobe
	input wire logic [7:0] host_wdata, // host write data
	output logic [7:0] host_rdata, // read data, held until next read
	input wire logic [7:0] pa_in, // port a line levels
	output logic [7:0] pa_out, // port a drive values
	output logic [7:0] pa_oe_n, // port a enables, low drives
	input wire logic [7:0] pb_in, // port b line levels
	output logic [7:0] pb_out, // port b drive values
	output logic [7:0] pb_oe_n, // port b enables, low drives
	input wire logic [7:0] pc_in, // port c line levels
	output logic [7:0] pc_out, // port c drive values
	output logic [7:0] pc_oe_n // port c enables, low drives
);
	typedef struct packed {
		logic configured;
		logic [6:0] cw;
		logic [7:0] pa_lat;
		logic [7:0] pb_lat;
		logic [7:0] pc_lat;
		logic inte_ai;
		logic inte_ao;
		logic inte_b;
		logic [7:0] rdata;
	} tppio_state_t;

	tppio_state_t q;
	tppio_state_t d;
	logic [23:0] pins_s;
	logic [7:0] pa_s;
	logic [7:0] pb_s;
	logic [7:0] pc_s;
	logic sel_a;
	logic sel_b;
	logic sel_c;
	logic sel_ctrl;
	logic mode_wr;
	logic a_m1;
	logic a_m2;
	logic a_in;
	logic b_m1;
	logic b_in;
	logic [7:0] c_own;
	logic [7:0] c_hs_drv;
	logic [7:0] c_hs_val;
	logic [7:0] c_drv;
	logic [7:0] c_view;
	logic [7:0] pa_view;
	logic [7:0] pb_view;

	tppio_hs_if hs_a ();
	tppio_hs_if hs_b ();

	// every pin passes two flops before any logic reads it
	tppio_sync #(.W(24)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.din({pc_in, pb_in, pa_in}),
		.dout(pins_s)
	);
	assign pa_s = pins_s[7:0];
	assign pb_s = pins_s[15:8];
	assign pc_s = pins_s[23:16];

	// full 16-bit address decode
	always_comb begin
		sel_a = 1'b0;
		sel_b = 1'b0;
		sel_c = 1'b0;
		sel_ctrl = 1'b0;
		if (host_addr == tppio_pkg::ADDR_PORT_A) begin
			sel_a = 1'b1;
		end else if (host_addr == tppio_pkg::ADDR_PORT_B) begin
			sel_b = 1'b1;
		end else if (host_addr == tppio_pkg::ADDR_PORT_C) begin
			sel_c = 1'b1;
		end else if (host_addr == tppio_pkg::ADDR_CTRL) begin
			sel_ctrl = 1'b1;
		end
	end

	// a mode word is a control-address write with bit 7 high
	assign mode_wr = host_wr & sel_ctrl & host_wdata[tppio_pkg::CW_MODE_SET];

	// group a: bits 6..3, group b: bits 2..0
	assign a_m2 = q.configured & q.cw[tppio_pkg::CW_A_MODE_HI];
	assign a_m1 = q.configured & (q.cw[tppio_pkg::CW_A_MODE_HI:tppio_pkg::CW_A_MODE_LO]
		== tppio_pkg::A_MODE_STROBED);
	assign a_in = q.cw[tppio_pkg::CW_A_DIR];
	assign b_m1 = q.configured & q.cw[tppio_pkg::CW_B_MODE];
	assign b_in = q.cw[tppio_pkg::CW_B_DIR];

	// channel a serves strobed in, latched out, or both in mode 2
	assign hs_a.clr = mode_wr;
	assign hs_a.rd = host_rd & sel_a;
	assign hs_a.wr = host_wr & sel_a;
	assign hs_a.m_in = a_m2 | (a_m1 & a_in);
	assign hs_a.m_out = a_m2 | (a_m1 & ~a_in);
	assign hs_a.inte_in = q.inte_ai;
	assign hs_a.inte_out = q.inte_ao;
	assign hs_a.stb_n = pc_s[tppio_pkg::PC_A_STB];
	assign hs_a.ack_n = pc_s[tppio_pkg::PC_A_ACK];
	assign hs_a.pins = pa_s;

	// channel b has no bidirectional role
	assign hs_b.clr = mode_wr;
	assign hs_b.rd = host_rd & sel_b;
	assign hs_b.wr = host_wr & sel_b;
	assign hs_b.m_in = b_m1 & b_in;
	assign hs_b.m_out = b_m1 & ~b_in;
	assign hs_b.inte_in = q.inte_b;
	assign hs_b.inte_out = q.inte_b;
	assign hs_b.stb_n = pc_s[tppio_pkg::PC_B_STB];
	assign hs_b.ack_n = pc_s[tppio_pkg::PC_B_STB];
	assign hs_b.pins = pb_s;

	tppio_hs u_hs_a (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.hs(hs_a)
	);

	tppio_hs u_hs_b (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.hs(hs_b)
	);

	// port c lines claimed by handshakes, and what they drive
	always_comb begin
		c_own = 8'h00;
		c_hs_drv = 8'h00;
		c_hs_val = 8'h00;
		if (a_m2) begin
			c_own[7:3] = 5'h1f;
			c_hs_drv[tppio_pkg::PC_A_INTR] = 1'b1;
			c_hs_drv[tppio_pkg::PC_A_IBF] = 1'b1;
			c_hs_drv[tppio_pkg::PC_A_OBF] = 1'b1;
		end else if (a_m1 && a_in) begin
			c_own[5:3] = 3'h7;
			c_hs_drv[tppio_pkg::PC_A_INTR] = 1'b1;
			c_hs_drv[tppio_pkg::PC_A_IBF] = 1'b1;
		end else if (a_m1) begin
			c_own[tppio_pkg::PC_A_INTR] = 1'b1;
			c_own[7:6] = 2'h3;
			c_hs_drv[tppio_pkg::PC_A_INTR] = 1'b1;
			c_hs_drv[tppio_pkg::PC_A_OBF] = 1'b1;
		end
		if (b_m1) begin
			c_own[2:0] = 3'h7;
			c_hs_drv[tppio_pkg::PC_B_INTR] = 1'b1;
			c_hs_drv[tppio_pkg::PC_B_FLAG] = 1'b1;
		end
		c_hs_val[tppio_pkg::PC_A_INTR] = hs_a.intr;
		c_hs_val[tppio_pkg::PC_A_IBF] = hs_a.ibf;
		c_hs_val[tppio_pkg::PC_A_OBF] = hs_a.obf_n;
		c_hs_val[tppio_pkg::PC_B_INTR] = hs_b.intr;
		c_hs_val[tppio_pkg::PC_B_FLAG] = b_in ? hs_b.ibf : hs_b.obf_n;
	end

	// free c lines follow their half's direction, independently
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pc
			logic half_in;
			assign half_in = (gi >= 4) ? q.cw[tppio_pkg::CW_CU_DIR]
				: q.cw[tppio_pkg::CW_CL_DIR];
			assign c_drv[gi] = c_own[gi] ? c_hs_drv[gi] : (q.configured & ~half_in);
			assign pc_out[gi] = c_hs_drv[gi] ? c_hs_val[gi] : q.pc_lat[gi];
			assign c_view[gi] = c_drv[gi] ? pc_out[gi] : pc_s[gi];
		end
	endgenerate
	assign pc_oe_n = ~c_drv;

	// nothing drives until a mode word arrives; mode 2 drives a on ack only
	assign pa_out = q.pa_lat;
	assign pa_oe_n = {8{~(q.configured & (a_m2 ? ~pc_s[tppio_pkg::PC_A_ACK] : ~a_in))}};
	assign pb_out = q.pb_lat;
	assign pb_oe_n = {8{~(q.configured & ~b_in)}};

	// read view: strobed latch, live inputs, or own latch for outputs
	assign pa_view = hs_a.m_in ? hs_a.in_latch : ((a_in || !q.configured) ? pa_s : q.pa_lat);
	assign pb_view = hs_b.m_in ? hs_b.in_latch : ((b_in || !q.configured) ? pb_s : q.pb_lat);

	// host writes and reads; control port is write-only and reads zero
	always_comb begin
		d = q;
		if (host_rd) begin
			if (sel_a) begin
				d.rdata = pa_view;
			end else if (sel_b) begin
				d.rdata = pb_view;
			end else if (sel_c) begin
				d.rdata = c_view;
			end else begin
				d.rdata = tppio_pkg::RDATA_RST;
			end
		end
		if (host_wr) begin
			if (sel_a) begin
				d.pa_lat = host_wdata;
			end else if (sel_b) begin
				d.pb_lat = host_wdata;
			end else if (sel_c) begin
				d.pc_lat = host_wdata;
			end else if (sel_ctrl && host_wdata[tppio_pkg::CW_MODE_SET]) begin
				d.configured = 1'b1;
				d.cw = host_wdata[6:0];
				d.pa_lat = tppio_pkg::LATCH_RST;
				d.pb_lat = tppio_pkg::LATCH_RST;
				d.pc_lat = tppio_pkg::LATCH_RST;
				d.inte_ai = 1'b0;
				d.inte_ao = 1'b0;
				d.inte_b = 1'b0;
			end else if (sel_ctrl) begin
				// latch bit moves even if a handshake owns the pin
				d.pc_lat[host_wdata[tppio_pkg::BSR_SEL_HI:tppio_pkg::BSR_SEL_LO]] =
					host_wdata[tppio_pkg::BSR_VAL];
				case (host_wdata[tppio_pkg::BSR_SEL_HI:tppio_pkg::BSR_SEL_LO])
					3'(tppio_pkg::PC_A_STB): d.inte_ai = host_wdata[tppio_pkg::BSR_VAL];
					3'(tppio_pkg::PC_A_ACK): d.inte_ao = host_wdata[tppio_pkg::BSR_VAL];
					3'(tppio_pkg::PC_B_STB): d.inte_b = host_wdata[tppio_pkg::BSR_VAL];
					default: d.inte_b = q.inte_b;
				endcase
			end
		end
	end

	// reset clears the latches; all lines float until the host programs a mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{configured: 1'b0, cw: tppio_pkg::CW_RST, pa_lat: tppio_pkg::LATCH_RST,
				pb_lat: tppio_pkg::LATCH_RST, pc_lat: tppio_pkg::LATCH_RST,
				inte_ai: 1'b0, inte_ao: 1'b0, inte_b: 1'b0, rdata: tppio_pkg::RDATA_RST};
		end else begin
			q <= d;
		end
	end

	assign host_rdata = q.rdata;
endmodule : tppio_top

// [bench/tppio_chk_sva.sv]
// port checks for the parallel interface unit
// assumes binding onto tppio_top, one core_clk domain
`timescale 1ns/1ps
module tppio_chk (
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset, low active
	input wire logic [15:0] host_addr, // address
	input wire logic host_rd, // read strobe
	input wire logic host_wr, // write strobe
	input wire logic [7:0] host_wdata, // write data
	input wire logic [7:0] host_rdata, // read data
	input wire logic [7:0] pa_in, // a pins
	input wire logic [7:0] pa_out, // a drive
	input wire logic [7:0] pa_oe_n, // a enables
	input wire logic [7:0] pb_in, // b pins
	input wire logic [7:0] pb_out, // b drive
	input wire logic [7:0] pb_oe_n, // b enables
	input wire logic [7:0] pc_in, // c pins
	input wire logic [7:0] pc_out, // c drive
	input wire logic [7:0] pc_oe_n // c enables
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// control writes; bit writes judged only in plain mode 0, no flag lines
	wire logic cw_wr = host_wr && host_addr == tppio_pkg::ADDR_CTRL;
	wire logic mw_wr = cw_wr && host_wdata[7];
	wire logic bw_wr = cw_wr && !host_wdata[7] && pc_oe_n == 8'h00;

	a_word_92: assert property (mw_wr && host_wdata == 8'h92 |=>
		pa_oe_n == 8'hff && pb_oe_n == 8'hff && pc_oe_n == 8'h00 && pc_out == 8'h00)
		else $error("word 92 setup wrong");
	a_mode0_dirs: assert property (mw_wr && host_wdata[6:5] == 2'h0 && !host_wdata[2] |=>
		pa_oe_n == {8{$past(host_wdata[4])}} && pc_oe_n[7:4] == {4{$past(host_wdata[3])}}
		&& pb_oe_n == {8{$past(host_wdata[1])}} && pc_oe_n[3:0] == {4{$past(host_wdata[0])}})
		else $error("mode 0 directions wrong");
	a_mode_clear: assert property (mw_wr |=> pa_out == 8'h00 && pb_out == 8'h00)
		else $error("latches not cleared");
	a_bit_write: assert property (bw_wr |=>
		pc_out[$past(host_wdata[3:1])] == $past(host_wdata[0]))
		else $error("bit write wrong");
	a_bit_others: assert property (bw_wr |=>
		((pc_out ^ $past(pc_out)) & ~(8'h01 << $past(host_wdata[3:1]))) == 8'h00)
		else $error("bit write disturbed others");
	a_port_a_wr: assert property (host_wr && host_addr == tppio_pkg::ADDR_PORT_A
		&& pa_oe_n == 8'h00 |=> pa_out == $past(host_wdata))
		else $error("port a latch wrong");
	a_data_not_ctrl: assert property (host_wr && host_addr == tppio_pkg::ADDR_PORT_C
		&& pc_oe_n == 8'h00 |=> pc_oe_n == 8'h00 && pc_out == $past(host_wdata))
		else $error("data write taken as control");
	a_ctrl_rd_zero: assert property (host_rd && host_addr == tppio_pkg::ADDR_CTRL |=>
		host_rdata == 8'h00)
		else $error("control read not zero");
	a_unmapped_rd: assert property (host_rd && host_addr != tppio_pkg::ADDR_PORT_A
		&& host_addr != tppio_pkg::ADDR_PORT_B && host_addr != tppio_pkg::ADDR_PORT_C |=>
		host_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata))
		else $error("read data moved");
endmodule : tppio_chk

bind tppio_top tppio_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr),
	.host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
	.pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pb_in), .pb_out(pb_out),
	.pb_oe_n(pb_oe_n), .pc_in(pc_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n));

// [bench/tppio_periph.sv]
// peripheral side of the 24 port lines
// assumes the bench sets the levels the equipment would drive
`timescale 1ns/1ps
module tppio_periph (
	input wire logic [23:0] outs, // unit drive, c b a
	input wire logic [23:0] oe_n, // unit enables, c b a
	input wire logic [23:0] ext, // equipment levels
	output logic [23:0] pins // line levels seen
);
	// a line the unit drives shows its value; the equipment never fights it
	assign pins = (outs & ~oe_n) | (ext & oe_n);
endmodule : tppio_periph

// [bench/tb_top.sv]
// self-checking bench for the parallel interface unit
// assumes tppio_top, tppio_periph and the checker compiled before it
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] host_addr = 16'h0000;
	logic host_rd = 1'b0;
	logic host_wr = 1'b0;
	logic [7:0] host_wdata = 8'h00;
	logic [7:0] host_rdata, pa_out, pa_oe_n, pb_out, pb_oe_n, pc_out, pc_oe_n;
	logic [23:0] ext = 24'h00_0000;
	logic [23:0] pins;
	logic [7:0] exp_c;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;

	// 250 MHz clock
	always #2 core_clk = ~core_clk;

	tppio_top uut (.core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr),
		.host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.pa_in(pins[7:0]), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pins[15:8]),
		.pb_out(pb_out), .pb_oe_n(pb_oe_n), .pc_in(pins[23:16]), .pc_out(pc_out),
		.pc_oe_n(pc_oe_n));
	tppio_periph u_periph (.outs({pc_out, pb_out, pa_out}), .oe_n({pc_oe_n, pb_oe_n, pa_oe_n}),
		.ext(ext), .pins(pins));

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask : chk

	// host cycles: strobe held one cycle, launched at the falling edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge core_clk);
		host_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge core_clk);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge core_clk);
		host_rd = 1'b0;
		d = host_rdata;
	endtask : rd

	// pins need two sync flops plus an edge detect before they count
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask : idle

	task automatic t_word92;
		logic [7:0] d;
		chk("oe before mode", 8'hff, pc_oe_n);
		wr(tppio_pkg::ADDR_CTRL, 8'h92);
		chk("pa_oe_n", 8'hff, pa_oe_n);
		chk("pb_oe_n", 8'hff, pb_oe_n);
		chk("pc_oe_n", 8'h00, pc_oe_n);
		ext[15:0] = 16'h5a3c;
		idle(4);
		rd(tppio_pkg::ADDR_PORT_A, d);
		chk("read a", 8'h3c, d);
		rd(tppio_pkg::ADDR_CTRL, d);
		chk("read ctrl", 8'h00, d);
		rd(tppio_pkg::ADDR_PORT_B, d);
		chk("read b", 8'h5a, d);
		rd(16'h00c9, d);
		chk("read unmapped", 8'h00, d);
		wr(tppio_pkg::ADDR_PORT_C, 8'h81);
		chk("c out", 8'h81, pc_out);
		$display("test word92 done");
	endtask : t_word92

	task automatic t_bits;
		wr(tppio_pkg::ADDR_CTRL, 8'h80);
		exp_c = 8'h00;
		for (int i = 0; i < 8; i++) begin
			wr(tppio_pkg::ADDR_CTRL, {4'h0, 3'(i), 1'b1});
			exp_c[i] = 1'b1;
			chk("bit set", exp_c, pc_out);
		end
		for (int i = 0; i < 8; i += 2) begin
			wr(tppio_pkg::ADDR_CTRL, {4'h0, 3'(i), 1'b0});
			exp_c[i] = 1'b0;
			chk("bit clear", exp_c, pc_out);
		end
		wr(tppio_pkg::ADDR_PORT_C, 8'h9b);
		chk("c data", 8'h9b, pc_out);
		chk("c oe", 8'h00, pc_oe_n);
		wr(tppio_pkg::ADDR_PORT_A, 8'ha5);
		chk("a out", 8'ha5, pa_out);
		wr(tppio_pkg::ADDR_CTRL, 8'h80);
		chk("a cleared", 8'h00, pa_out);
		chk("c cleared", 8'h00, pc_out);
		$display("test bits done");
	endtask : t_bits

	task automatic t_split;
		logic [7:0] d;
		wr(tppio_pkg::ADDR_CTRL, 8'h88);
		chk("split c", 8'hf0, pc_oe_n);
		chk("a out dir", 8'h00, pa_oe_n);
		chk("b out dir", 8'h00, pb_oe_n);
		wr(tppio_pkg::ADDR_CTRL, 8'h83);
		chk("split c", 8'h0f, pc_oe_n);
		chk("b in dir", 8'hff, pb_oe_n);
		wr(tppio_pkg::ADDR_PORT_C, 8'h5a);
		ext[23:16] = 8'h36;
		idle(4);
		rd(tppio_pkg::ADDR_PORT_C, d);
		chk("read c split", 8'h56, d);
		$display("test split done");
	endtask : t_split

	task automatic t_strobe;
		logic [7:0] d;
		ext[7:0] = 8'hc3;
		wr(tppio_pkg::ADDR_CTRL, 8'hb0);
		// first strobe without interrupt enable, then with it
		for (int en = 0; en < 2; en++) begin
			if (en == 1) begin
				wr(tppio_pkg::ADDR_CTRL, 8'h09);
			end
			ext[20] = 1'b0;
			idle(4);
			ext[20] = 1'b1;
			idle(6);
			chk("flags", en == 1 ? 8'h28 : 8'h20, pc_out & 8'h28);
			rd(tppio_pkg::ADDR_PORT_A, d);
			chk("strobed a", 8'hc3, d);
			chk("flags cleared", 8'h00, pc_out & 8'h28);
		end
		$display("test strobe done");
	endtask : t_strobe

	task automatic t_portb;
		wr(tppio_pkg::ADDR_CTRL, 8'h84);
		chk("obf idle", 8'h02, pc_out & 8'h02);
		wr(tppio_pkg::ADDR_PORT_B, 8'h66);
		chk("b out", 8'h66, pb_out);
		chk("obf set", 8'h00, pc_out & 8'h02);
		$display("test portb done");
	endtask : t_portb

	task automatic t_mode2;
		ext[22] = 1'b1;
		wr(tppio_pkg::ADDR_CTRL, 8'hc0);
		idle(4);
		chk("a released", 8'hff, pa_oe_n);
		ext[22] = 1'b0;
		idle(4);
		chk("a driven", 8'h00, pa_oe_n);
		$display("test mode2 done");
	endtask : t_mode2

	// a latched out with ack, b strobed in; lines settle before the mode word
	task automatic t_handout;
		logic [7:0] d;
		ext[22] = 1'b1;
		ext[15:8] = 8'h7e;
		idle(4);
		wr(tppio_pkg::ADDR_CTRL, 8'ha6);
		chk("hs idle", 8'h80, pc_out & 8'h82);
		wr(tppio_pkg::ADDR_PORT_A, 8'h3c);
		chk("a latched", 8'h3c, pa_out);
		chk("a obf set", 8'h00, pc_out & 8'h80);
		ext[22] = 1'b0;
		idle(4);
		chk("a obf ack", 8'h80, pc_out & 8'h80);
		ext[22] = 1'b1;
		ext[18] = 1'b0;
		idle(4);
		ext[18] = 1'b1;
		idle(4);
		chk("b ibf", 8'h02, pc_out & 8'h02);
		rd(tppio_pkg::ADDR_PORT_B, d);
		chk("strobed b", 8'h7e, d);
		chk("b ibf cleared", 8'h00, pc_out & 8'h02);
		$display("test handout done");
	endtask : t_handout

	// main sequence after a 20-cycle reset
	initial begin
		repeat (20) @(negedge core_clk);
		rst_n = 1'b1;
		t_word92();
		t_bits();
		t_split();
		t_strobe();
		t_portb();
		t_mode2();
		t_handout();
		complete_run();
	end

	// hang guard, far beyond the roughly 150 cycles the tests take
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			complete_run();
		end
	end
endmodule : tb_top
